// File: rtl/mai_top.v
// Monitor alert logic: fault status, mask, temperature modes, alert pin, register file
`timescale 1ns/10ps
`include "mai_regs.vh"
module mai_top #(
   parameter [6:0] SLAVE_ADDR = 7'h2a  // Arbitrary value
) (
   input  wire        clock_i,
   input  wire        srst_i,
   input  wire        scl_i,
   input  wire        sda_i,
   output reg         sda_o,
   output wire        sda_oe_o,
   output reg         alert_n_o,
   output reg         alert_oe_o,
   input  wire        meas_valid_i,
   input  wire [31:0] meas_volt_i,
   input  wire [7:0]  meas_temp_i,
   input  wire [2:0]  meas_temp_frac_i,
   output reg         monitor_run_o
);
   reg  [7:0] cfg;
   reg  [7:0] status;
   reg  [7:0] mask;
   reg  [7:0] tmode;
   reg  [7:0] hot_limit;
   reg  [7:0] hot_hysteresis_limit;
   reg  [7:0] limit_mem [0:7];
   reg  [7:0] vdata [0:3];
   reg  [7:0] temp_data;
   reg  [2:0] temp_frac;
   reg        hot_state;
   reg        cmp_above;

   wire [7:0] ptr;
   wire       wr;
   wire [7:0] wr_data;
   wire       rd;
   reg  [7:0] rd_data;
   reg  [7:0] rd_ext;

   ////////////////////////////////////////////////////////////////////////
   // Serial slave
   mai_smb_slave u_slave (
      .clock_i      (clock_i),
      .srst_i       (srst_i),
      .scl_i        (scl_i),
      .sda_i        (sda_i),
      .own_addr_i   (SLAVE_ADDR),
      .alert_pend_i (alert_oe_o),
      .rd_data_i    (rd_data),
      .rd_ext_i     (rd_ext),
      .sda_oe_o     (sda_oe_o),
      .ptr_o        (ptr),
      .wr_o         (wr),
      .wr_data_o    (wr_data),
      .rd_o         (rd)
   );

   ////////////////////////////////////////////////////////////////////////
   // Conversion evaluation
   wire       soft_rst = wr && (ptr == `MAI_OFS_CFG) && wr_data[`MAI_CFG_SOFT_RST];
   wire       rst_all  = srst_i | soft_rst;
   wire       run      = cfg[`MAI_CFG_RUN] & ~cfg[`MAI_CFG_ALERT_CLR];
   wire       conv     = meas_valid_i & run;
   wire [7:0] lim_idx  = ptr - `MAI_OFS_LIM_FIRST;
   wire       lim_sel  = (ptr >= `MAI_OFS_LIM_FIRST) && (ptr <= `MAI_OFS_LIM_LAST);
   wire       mode_cmp  = (tmode[1:0] == `MAI_MODE_CMP);
   wire       mode_once = (tmode[1:0] == `MAI_MODE_ONCE);
   wire       above_hot  = $signed(meas_temp_i) > $signed(hot_limit);
   wire       below_hyst = $signed(meas_temp_i) < $signed(hot_hysteresis_limit);

   reg  [3:0] vfault;
   reg        tset;
   reg  [4:0] set_v;
   reg  [4:0] clr_v;
   reg  [7:0] next_status;
   integer    i;
   integer    j;

   always @* begin
      for (i = 0; i < 4; i = i + 1) begin
         // High limit at even index, low limit at odd index per input
         vfault[i] = (meas_volt_i[8*i +: 8] > limit_mem[2*i]) ||
                     (meas_volt_i[8*i +: 8] < limit_mem[2*i+1]);
      end
      if (mode_cmp) begin
         tset = above_hot;
      end else if (mode_once) begin
         tset = (above_hot & ~hot_state) | (hot_state & below_hyst);
      end else begin
         tset = above_hot | (hot_state & ~below_hyst);
      end
      // Re-raised on every conversion while the fault persists, except temperature in one-time mode
      set_v = conv ? ({tset, vfault} & ~mask[4:0]) : 5'h00;
      clr_v = 5'h00;
      if (rd && ptr == `MAI_OFS_STATUS) begin
         clr_v = 5'h1f;
         if (mode_cmp && cmp_above) begin
            clr_v[`MAI_BIT_TEMP] = 1'b0;
         end
      end
      if (conv && mode_cmp && !above_hot) begin
         clr_v[`MAI_BIT_TEMP] = 1'b1;
      end
      // Set wins over a clear landing in the same cycle
      next_status = {3'b000, ((status[4:0] & ~clr_v) | set_v) & ~mask[4:0]};
   end

   ////////////////////////////////////////////////////////////////////////
   // Register file
   always @(posedge clock_i) begin
      if (rst_all) begin
         cfg                  <= `MAI_RST_CFG;
         status               <= `MAI_RST_STATUS;
         mask                 <= `MAI_RST_MASK;
         tmode                <= `MAI_RST_TMODE;
         hot_limit            <= `MAI_RST_HOT;
         hot_hysteresis_limit <= `MAI_RST_HYST;
         for (j = 0; j < 4; j = j + 1) begin
            limit_mem[2*j]   <= `MAI_RST_VOLTAGE_HIGH_LIMIT;
            limit_mem[2*j+1] <= `MAI_RST_VOLTAGE_LOW_LIMIT;
            vdata[j]         <= 8'h00;
         end
         temp_data <= 8'h00;
         temp_frac <= 3'h0;
         hot_state <= 1'b0;
         cmp_above <= 1'b0;
      end else begin
         status <= next_status;
         if (conv) begin
            for (j = 0; j < 4; j = j + 1) begin
               vdata[j] <= meas_volt_i[8*j +: 8];
            end
            temp_data <= meas_temp_i;
            temp_frac <= meas_temp_frac_i;
            cmp_above <= above_hot;
            if (above_hot) begin
               hot_state <= 1'b1;
            end else if (below_hyst) begin
               hot_state <= 1'b0;
            end
         end
         if (wr) begin
            if (ptr == `MAI_OFS_CFG) begin
               cfg <= wr_data & `MAI_CFG_WMASK;
            end else if (ptr == `MAI_OFS_MASK) begin
               mask <= wr_data & `MAI_SRC_WMASK;
            end else if (ptr == `MAI_OFS_TMODE) begin
               tmode <= wr_data & `MAI_TMODE_WMASK;
            end else if (ptr == `MAI_OFS_HOT) begin
               hot_limit <= wr_data;
            end else if (ptr == `MAI_OFS_HYST) begin
               hot_hysteresis_limit <= wr_data;
            end else if (lim_sel) begin
               limit_mem[lim_idx[2:0]] <= wr_data;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path; second byte of a word is the companion byte
   always @* begin
      rd_data = 8'h00;
      rd_ext  = 8'h00;
      if (ptr == `MAI_OFS_STATUS) begin
         rd_data = status;
      end else if (ptr == `MAI_OFS_CFG) begin
         rd_data = cfg;
      end else if (ptr == `MAI_OFS_MASK) begin
         rd_data = mask;
      end else if (ptr == `MAI_OFS_TMODE) begin
         rd_data = tmode;
      end else if (ptr == `MAI_OFS_HOT) begin
         rd_data = hot_limit;
      end else if (ptr == `MAI_OFS_HYST) begin
         rd_data = hot_hysteresis_limit;
      end else if (lim_sel) begin
         rd_data = limit_mem[lim_idx[2:0]];
      end else if (ptr == `MAI_OFS_TEMP) begin
         rd_data = temp_data;
         rd_ext  = {temp_frac, 5'h00};
      end else if (ptr >= `MAI_OFS_VDATA0 && ptr <= `MAI_OFS_VDATA3) begin
         rd_data = vdata[ptr[1:0]];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Alert pin and monitor enable; the slave stays out of soft reset
   always @(posedge clock_i) begin
      if (srst_i) begin
         alert_n_o     <= 1'b0;
         alert_oe_o    <= 1'b0;
         sda_o         <= 1'b0;
         monitor_run_o <= 1'b0;
      end else begin
         alert_n_o     <= 1'b0;
         sda_o         <= 1'b0;
         alert_oe_o    <= cfg[`MAI_CFG_ALERT_EN] & ~cfg[`MAI_CFG_ALERT_CLR] &
                          (|(status[4:0] & ~mask[4:0]));
         monitor_run_o <= run;
      end
   end
endmodule // mai_top

// File: pkg/mai_regs.vh
// Constants of the monitor alert logic: offsets, fields, reset values
// Function
// - One fault flag per source, bits 0-4
// - Voltage outside low/high limits sets flag
// - Voltage limits reset to 1.1/0.9 nominal
// - Hot limit resets 80, hysteresis 65
// - Mask bit suppresses flag and alert
// - Mode 00/11 default, 01 one-time, 10 comparator
// - Status read clears flags and alert
// - Comparator read keeps live temperature flag
// - Read after fault gone clears all
// - Persisting fault re-alerts next conversion, temperature in one-time mode excepted
// - Alert-enable zero keeps alert released
// - Alert never stops conversions or readback
// - Alert is active-low open-drain
// - Default mode repeats until below hysteresis
// - One-time mode next alert below hysteresis
// - Comparator holds flag while above hot
// - Write byte stores data at command
// - Read byte returns commanded register
// - Receive byte uses last command pointer
// - Read word sends high then low
// - Alert-clear bit releases alert, halts monitoring
// - Alert response returns own address, keeps alert
`ifndef MAI_REGS_VH
`define MAI_REGS_VH

`define MAI_OFS_VDATA0    8'h20
`define MAI_OFS_VDATA3    8'h23
`define MAI_OFS_TEMP      8'h27
`define MAI_OFS_LIM_FIRST 8'h2b
`define MAI_OFS_LIM_LAST  8'h32
`define MAI_OFS_HOT       8'h39
`define MAI_OFS_HYST      8'h3a
`define MAI_OFS_CFG       8'h40
`define MAI_OFS_STATUS    8'h41
`define MAI_OFS_MASK      8'h43
`define MAI_OFS_TMODE     8'h4b

`define MAI_RST_CFG       8'h08
`define MAI_RST_STATUS    8'h00
`define MAI_RST_MASK      8'h00
`define MAI_RST_TMODE     8'h00
`define MAI_RST_HOT       8'h50
`define MAI_RST_HYST      8'h41
`define MAI_RST_VOLTAGE_HIGH_LIMIT     8'hd3
`define MAI_RST_VOLTAGE_LOW_LIMIT      8'had

`define MAI_CFG_RUN       0
`define MAI_CFG_ALERT_EN  1
`define MAI_CFG_ALERT_CLR 3
`define MAI_CFG_SOFT_RST  7
`define MAI_CFG_WMASK     8'h3b
`define MAI_SRC_WMASK     8'h1f
`define MAI_TMODE_WMASK   8'h03
`define MAI_BIT_TEMP      4

`define MAI_MODE_CMP      2'b10
`define MAI_MODE_ONCE     2'b01

`define MAI_ARA_ADDR      7'h0c
`define MAI_BITS_PER_BYTE 4'h8

`endif

// File: rtl/mai_smb_slave.v
// Two-wire register-access slave: framing, acknowledge, pointer, alert response
`timescale 1ns/10ps
`include "mai_regs.vh"
module mai_smb_slave (
   input  wire       clock_i,
   input  wire       srst_i,
   input  wire       scl_i,
   input  wire       sda_i,
   input  wire [6:0] own_addr_i,
   input  wire       alert_pend_i,
   input  wire [7:0] rd_data_i,
   input  wire [7:0] rd_ext_i,
   output reg        sda_oe_o,
   output reg  [7:0] ptr_o,
   output reg        wr_o,
   output reg  [7:0] wr_data_o,
   output reg        rd_o
);
   localparam ST_IDLE = 3'd0;
   localparam ST_ADDR = 3'd1;
   localparam ST_RX   = 3'd2;
   localparam ST_ACK  = 3'd3;
   localparam ST_TX   = 3'd4;
   localparam ST_TACK = 3'd5;

   reg        scl_m, scl_s, scl_d;
   reg        sda_m, sda_s, sda_d;
   reg  [2:0] state;
   reg  [3:0] cnt;
   reg  [7:0] shreg;
   reg  [7:0] txreg;
   reg  [1:0] byte_idx;
   reg        is_read;
   reg        is_ara;
   reg        ack_ok;
   reg        master_ack;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers, first stage read only by the second
   always @(posedge clock_i) begin
      if (srst_i) begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         scl_d <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_m <= scl_i;
         scl_s <= scl_m;
         scl_d <= scl_s;
         sda_m <= sda_i;
         sda_s <= sda_m;
         sda_d <= sda_s;
      end
   end

   wire scl_rise = scl_s & ~scl_d;
   wire scl_fall = ~scl_s & scl_d;
   wire start_c  = scl_s & scl_d & sda_d & ~sda_s;
   wire stop_c   = scl_s & scl_d & ~sda_d & sda_s;
   wire own_hit  = (shreg[7:1] == own_addr_i);
   wire ara_hit  = (shreg[7:1] == `MAI_ARA_ADDR) & shreg[0] & alert_pend_i;

   ////////////////////////////////////////////////////////////////////////
   // Byte engine
   always @(posedge clock_i) begin
      if (srst_i) begin
         state      <= ST_IDLE;
         cnt        <= 4'h0;
         shreg      <= 8'h00;
         txreg      <= 8'h00;
         byte_idx   <= 2'd0;
         is_read    <= 1'b0;
         is_ara     <= 1'b0;
         ack_ok     <= 1'b0;
         master_ack <= 1'b0;
         sda_oe_o   <= 1'b0;
         ptr_o      <= 8'h00;
         wr_o       <= 1'b0;
         wr_data_o  <= 8'h00;
         rd_o       <= 1'b0;
      end else begin
         wr_o <= 1'b0;
         rd_o <= 1'b0;
         if (start_c) begin
            state    <= ST_ADDR;
            cnt      <= 4'h0;
            byte_idx <= 2'd0;
            sda_oe_o <= 1'b0;
         end else if (stop_c) begin
            state    <= ST_IDLE;
            sda_oe_o <= 1'b0;
         end else begin
            case (state)
               ST_ADDR, ST_RX: begin
                  if (scl_rise) begin
                     shreg <= {shreg[6:0], sda_s};
                     cnt   <= cnt + 4'h1;
                  end else if (scl_fall && cnt == `MAI_BITS_PER_BYTE) begin
                     state <= ST_ACK;
                     cnt   <= 4'h0;
                     if (state == ST_ADDR) begin
                        is_read  <= shreg[0];
                        is_ara   <= ara_hit;
                        ack_ok   <= own_hit | ara_hit;
                        sda_oe_o <= own_hit | ara_hit;
                     end else begin
                        // A third written byte is refused
                        ack_ok   <= (byte_idx != 2'd2);
                        sda_oe_o <= (byte_idx != 2'd2);
                        if (byte_idx == 2'd0) begin
                           ptr_o <= shreg;
                        end else if (byte_idx == 2'd1) begin
                           wr_o      <= 1'b1;
                           wr_data_o <= shreg;
                        end
                        if (byte_idx != 2'd2) begin
                           byte_idx <= byte_idx + 2'd1;
                        end
                     end
                  end
               end
               ST_ACK: begin
                  if (scl_fall) begin
                     if (!ack_ok) begin
                        state    <= ST_IDLE;
                        sda_oe_o <= 1'b0;
                     end else if (is_read) begin
                        // Alert response answers the address, never clears
                        txreg    <= is_ara ? {own_addr_i, 1'b0} : rd_data_i;
                        sda_oe_o <= is_ara ? ~own_addr_i[6] : ~rd_data_i[7];
                        rd_o     <= ~is_ara;
                        byte_idx <= 2'd0;
                        state    <= ST_TX;
                     end else begin
                        sda_oe_o <= 1'b0;
                        state    <= ST_RX;
                     end
                  end
               end
               ST_TX: begin
                  if (scl_rise) begin
                     cnt <= cnt + 4'h1;
                     // Lost arbitration: another slave pulled a released bit low
                     if (is_ara && !sda_oe_o && !sda_s) begin
                        state <= ST_IDLE;
                     end
                  end else if (scl_fall) begin
                     if (cnt == `MAI_BITS_PER_BYTE) begin
                        sda_oe_o <= 1'b0;
                        state    <= ST_TACK;
                     end else begin
                        txreg    <= {txreg[6:0], 1'b0};
                        sda_oe_o <= ~txreg[6];
                     end
                  end
               end
               ST_TACK: begin
                  if (scl_rise) begin
                     master_ack <= ~sda_s;
                  end else if (scl_fall) begin
                     if (master_ack && !is_ara && byte_idx == 2'd0) begin
                        txreg    <= rd_ext_i;
                        sda_oe_o <= ~rd_ext_i[7];
                        byte_idx <= 2'd1;
                        cnt      <= 4'h0;
                        state    <= ST_TX;
                     end else begin
                        state <= ST_IDLE;
                     end
                  end
               end
               default: begin
                  state <= ST_IDLE;
               end
            endcase
         end
      end
   end
endmodule // mai_smb_slave

// File: sim/mai_monitor.sv
// Checker of the alert, bus data and run outputs of the monitor alert logic
`timescale 1ns/10ps
module mai_monitor (
   input logic clock_i,
   input logic srst_i,
   input logic scl_i,
   input logic sda_o,
   input logic sda_oe_o,
   input logic alert_n_o,
   input logic alert_oe_o,
   input logic meas_valid_i,
   input logic monitor_run_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (srst_i);
   //////////////////////////////////////////////////////////////////////////////
   alert_pin_a: assert property (alert_n_o == 1'b0)
      else $error("alert pin value not low");
   sda_pin_a: assert property (sda_o == 1'b0)
      else $error("data pin value not low");
   reset_quiet_a: assert property ($fell(srst_i) |-> (!alert_oe_o && !monitor_run_o)[*3])
      else $error("alert or run active after reset");
   // Alert only rises after a conversion result arrives
   rise_cause_a: assert property ($rose(alert_oe_o) |-> $past(meas_valid_i, 2) || $past(meas_valid_i, 3))
      else $error("alert rose without conversion");
   rise_run_a: assert property ($rose(alert_oe_o) |-> $past(monitor_run_o, 2))
      else $error("alert rose while monitoring halted");
   // A release comes from a bus access, seen as the slave pulling the data line low, or a conversion
   fall_cause_a: assert property ($fell(alert_oe_o) |-> sda_oe_o || $past(meas_valid_i, 2)
      || $past(meas_valid_i, 3))
      else $error("alert released without cause");
   sda_change_a: assert property ($changed(sda_oe_o) |-> !$past(scl_i, 2) && !$past(scl_i, 3))
      else $error("data changed while bus clock high");
   run_rise_a: assert property ($rose(monitor_run_o) |-> sda_oe_o)
      else $error("monitoring started without bus write");
   cover property ($rose(alert_oe_o));
   cover property ($fell(alert_oe_o));
   cover property ($rose(monitor_run_o));
endmodule // mai_monitor

bind mai_top mai_monitor i_mai_monitor (.clock_i, .srst_i, .scl_i, .sda_o, .sda_oe_o, .alert_n_o, .alert_oe_o,
   .meas_valid_i, .monitor_run_o);

// File: sim/mai_host.sv
// Two-wire host master model: drives the bus clock, pulls data low, samples the wired level
`timescale 1ns/10ps
module mai_host (
   output logic scl_o,
   output logic sda_oe_o,
   input  logic sda_i
);
   initial begin
      scl_o    = 1'b1;
      sda_oe_o = 1'b0;
   end
   //////////////////////////////////////////////////////////////////////////////
   // Data moves only with the clock low; sampled late in the high phase
   task automatic bit_x(input logic b, output logic r);
      scl_o = 1'b0;
      #200;
      sda_oe_o = ~b;
      #200;
      scl_o = 1'b1;
      #400;
      r = sda_i;
   endtask
   // High s gives start or repeated start, low s gives stop
   task automatic cond(input logic s);
      scl_o = 1'b0;
      #200;
      sda_oe_o = ~s;
      #200;
      scl_o = 1'b1;
      #400;
      sda_oe_o = s;
      #400;
   endtask
   task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic nak);
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], q[i]);
      end
      bit_x(ack_in, nak);
   endtask
endmodule // mai_host

// File: sim/testbench.sv
// Self-checking bench of the monitor alert logic driven through the bus host model
`timescale 1ns/10ps
`include "mai_regs.vh"
module testbench;
   typedef struct packed {
      logic [31:0] volt;
      logic [7:0]  temp;
      logic [7:0]  mask;
      logic [7:0]  stat;
   } mai_row_t;
   localparam logic [6:0]  SA  = 7'h2a;
   localparam logic [31:0] NOM = 32'hc0c0c0c0;
   localparam logic [31:0] V0H = 32'hc0c0c0d4;
   logic        clk, srst, mv, scl, h_oe, d_oe, d_sda, alert, an, run, n;
   logic [31:0] mvolt;
   logic [7:0]  mtemp, q0, q1;
   logic [2:0]  mfrac;
   int          fails, checks_done;
   wire         sda_w = ~h_oe & (~d_oe | d_sda);
   logic [7:0]  rst_ofs [10] = '{8'h40, 8'h41, 8'h43, 8'h4b, 8'h39, 8'h3a, 8'h2b, 8'h2c, 8'h32, 8'h7f};
   logic [7:0]  rst_val [10] = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h50, 8'h41, 8'hd3, 8'had, 8'had, 8'h00};
   mai_row_t    rows [8] = '{'{V0H, 8'h19, 8'h00, 8'h01}, '{32'hc0c0acc0, 8'h19, 8'h00, 8'h02},
      '{32'hc0d4c0c0, 8'h19, 8'h00, 8'h04}, '{32'hacc0c0c0, 8'h19, 8'h00, 8'h08},
      '{32'hd3adadd3, 8'h50, 8'h00, 8'h00}, '{NOM, 8'h51, 8'h00, 8'h10},
      '{32'hc0c0d4d4, 8'h19, 8'h01, 8'h02}, '{32'h00ff00ff, 8'h7f, 8'h1f, 8'h00}};
   mai_top i_mai_top (.clock_i(clk), .srst_i(srst), .scl_i(scl), .sda_i(sda_w), .sda_o(d_sda), .sda_oe_o(d_oe),
      .alert_n_o(an), .alert_oe_o(alert), .meas_valid_i(mv), .meas_volt_i(mvolt), .meas_temp_i(mtemp),
      .meas_temp_frac_i(mfrac), .monitor_run_o(run));
   mai_host host (.scl_o(scl), .sda_oe_o(h_oe), .sda_i(sda_w));
   //////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Without data this is the pointer-only write
   task automatic wr(input logic [7:0] c, input logic [7:0] d, input logic has_d);
      logic [7:0] q;
      logic       n0, n1, n2;
      @(negedge clk);
      host.cond(1'b1);
      host.xfer({SA, 1'b0}, 1'b1, q, n0);
      host.xfer(c, 1'b1, q, n1);
      n2 = 1'b0;
      if (has_d) host.xfer(d, 1'b1, q, n2);
      host.cond(1'b0);
      check(8'({n0, n1, n2}), 8'h00);
   endtask
   task automatic rd(input logic [7:0] c, input logic w, output logic [7:0] r0, output logic [7:0] r1);
      logic [7:0] q;
      logic       n0, n1, n2, x;
      @(negedge clk);
      host.cond(1'b1);
      host.xfer({SA, 1'b0}, 1'b1, q, n0);
      host.xfer(c, 1'b1, q, n1);
      host.cond(1'b1);
      host.xfer({SA, 1'b1}, 1'b1, q, n2);
      host.xfer(8'hff, ~w, r0, x);
      r1 = 8'h00;
      if (w) host.xfer(8'hff, 1'b1, r1, x);
      host.cond(1'b0);
      check(8'({n0, n1, n2}), 8'h00);
   endtask
   task automatic rx(input logic [6:0] a, output logic [7:0] q, output logic nak);
      logic x;
      @(negedge clk);
      host.cond(1'b1);
      host.xfer({a, 1'b1}, 1'b1, q, nak);
      if (!nak) host.xfer(8'hff, 1'b1, q, x);
      host.cond(1'b0);
   endtask
   task automatic st(input logic [7:0] e);
      logic [7:0] r0, r1;
      rd(`MAI_OFS_STATUS, 1'b0, r0, r1);
      check(r0, e);
   endtask
   task automatic al(input logic e);
      check(8'(alert), 8'(e));
      check(8'(an), 8'h00);
   endtask
   // Settle time fixed by the one-clock status and alert stages
   task automatic conv(input logic [31:0] v, input logic [7:0] t);
      @(negedge clk);
      mvolt = v;
      mtemp = t;
      mv = 1'b1;
      @(negedge clk);
      mv = 1'b0;
      repeat (3) @(negedge clk);
   endtask
   //////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      #5ms;
      fails++;
      tally_and_finish();
   end
   initial begin
      srst = 1'b1;
      mv = 1'b0;
      mvolt = NOM;
      mtemp = 8'h19;
      mfrac = 3'b101;
      repeat (16) @(negedge clk);
      srst = 1'b0;
      repeat (3) @(negedge clk);
      foreach (rst_ofs[i]) begin
         rd(rst_ofs[i], 1'b0, q0, q1);
         check(q0, rst_val[i]);
      end
      rx(7'h2b, q0, n);
      check(8'(n), 8'h01);
      wr(`MAI_OFS_CFG, 8'h03, 1'b1);
      check(8'(run), 8'h01);
      foreach (rows[i]) begin
         wr(`MAI_OFS_MASK, rows[i].mask, 1'b1);
         conv(rows[i].volt, rows[i].temp);
         al(rows[i].stat != 8'h00);
         st(rows[i].stat);
         al(1'b0);
      end
      wr(`MAI_OFS_MASK, 8'h00, 1'b1);
      wr(`MAI_OFS_CFG, 8'h01, 1'b1);
      conv(V0H, 8'h19);
      al(1'b0);
      st(8'h01);
      wr(`MAI_OFS_CFG, 8'h03, 1'b1);
      wr(`MAI_OFS_TMODE, 8'h03, 1'b1);
      conv(NOM, 8'h5a);
      al(1'b1);
      st(8'h10);
      al(1'b0);
      conv(NOM, 8'h46);
      al(1'b1);
      st(8'h10);
      conv(NOM, 8'h19);
      al(1'b0);
      wr(`MAI_OFS_TMODE, 8'h01, 1'b1);
      conv(NOM, 8'h5a);
      st(8'h10);
      conv(NOM, 8'h5a);
      al(1'b0);
      conv(NOM, 8'h3c);
      al(1'b1);
      st(8'h10);
      wr(`MAI_OFS_TMODE, 8'h02, 1'b1);
      conv(V0H, 8'h5a);
      al(1'b1);
      rd(`MAI_OFS_TEMP, 1'b1, q0, q1);
      check(q0, 8'h5a);
      check(q1, 8'ha0);
      rd(`MAI_OFS_VDATA0, 1'b0, q0, q1);
      check(q0, 8'hd4);
      rx(`MAI_ARA_ADDR, q0, n);
      check(8'(n), 8'h00);
      check(q0, {SA, 1'b0});
      al(1'b1);
      wr(`MAI_OFS_HOT, 8'h00, 1'b0);
      rx(SA, q0, n);
      check(q0, 8'h50);
      st(8'h11);
      al(1'b1);
      st(8'h10);
      conv(NOM, 8'h19);
      al(1'b0);
      st(8'h00);
      wr(`MAI_OFS_TMODE, 8'h00, 1'b1);
      conv(V0H, 8'h19);
      al(1'b1);
      wr(`MAI_OFS_CFG, 8'h0b, 1'b1);
      al(1'b0);
      check(8'(run), 8'h00);
      rx(`MAI_ARA_ADDR, q0, n);
      check(8'(n), 8'h01);
      st(8'h01);
      conv(V0H, 8'h19);
      st(8'h00);
      // Soft reset through the control byte reloads the limits
      wr(`MAI_OFS_HOT, 8'h20, 1'b1);
      wr(`MAI_OFS_CFG, 8'h83, 1'b1);
      rd(`MAI_OFS_HOT, 1'b0, q0, q1);
      check(q0, 8'h50);
      rd(`MAI_OFS_CFG, 1'b0, q0, q1);
      check(q0, 8'h08);
      wr(`MAI_OFS_CFG, 8'h03, 1'b1);
      mfrac = 3'b011;
      conv(V0H, 8'h19);
      al(1'b1);
      rd(`MAI_OFS_TEMP, 1'b1, q0, q1);
      check(q0, 8'h19);
      check(q1, 8'h60);
      // Mid-run reset with an alert pending
      @(negedge clk);
      srst = 1'b1;
      repeat (2) @(negedge clk);
      srst = 1'b0;
      repeat (3) @(negedge clk);
      al(1'b0);
      check(8'(run), 8'h00);
      st(8'h00);
      tally_and_finish();
   end
endmodule // testbench
